//--- design/srdt_regs.sv
`include "srdt_consts.svh"

// Function
// [RULE_01] Index written at port 22H selects register; data moves through port 23H.
// [RULE_02] Each data-port access consumes the index; software rewrites it every time.
// [RULE_03] Reserved bits reset to zero and read as zero.
// [RULE_04] Shadow A/B register bits 0-3 enable B0000H-BFFFFH segments ascending.
// [RULE_05] Shadow A/B register bits 4-7 enable A0000H-AFFFFH segments ascending.
// [RULE_06] Shadow C/D register bits 0-3 enable C0000H-CFFFFH segments ascending.
// [RULE_07] Shadow C/D register bits 4-7 enable D0000H-DFFFFH segments ascending.
// [RULE_08] Segment enables reset to zero; one enables shadow RAM.
// [RULE_09] Reserved register at B8H has no function.
// [RULE_10] Memory-type bit 0 set precharges row strobe in I/O and idle cycles.
// [RULE_11] Bit 0 resets to zero; then no precharge happens.
// [RULE_12] Bit 1 picks five cycles when one, three when zero; resets to one.
// [RULE_13] Bits 7-2 encode bank population and part size; others unsupported.
module srdt_regs
  import srdt_pkg::*;
(
  input  wire logic                   CLK,            // Double-rate CPU clock.
  input  wire logic                   NRST,           // Asynchronous reset, low.
  input  wire srdt_pkg::srdt_addr_type IO_ADDR,       // I/O address.
  input  wire logic                   IO_WR,          // I/O write strobe, one cycle.
  input  wire logic                   IO_RD,          // I/O read strobe, one cycle.
  input  wire srdt_pkg::srdt_byte_type IO_WDATA,      // I/O write data.
  input  wire logic                   CYC_IO,         // Current cycle is an I/O cycle.
  input  wire logic                   CYC_IDLE,       // Current cycle is an idle cycle.
  output srdt_pkg::srdt_byte_type     IO_RDATA,       // Read data, held.
  output logic                        IO_RVALID,      // Read data valid, one cycle.
  output srdt_pkg::srdt_seg_type      SHADOW_EN,      // Segment enables, A0000H upward.
  output logic                        RAS_PRECHARGE,  // Row-strobe precharge request.
  output srdt_pkg::srdt_bank_type     BANK_PRESENT,   // Populated banks.
  output srdt_pkg::srdt_bank_type     BANK_1MB,       // Banks with 1Mb parts.
  output logic                        TYPE_VALID      // Bank code is supported.
);
  import srdt_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  srdt_byte_type  index;
  logic           index_valid;
  srdt_byte_type  shadow_ab;
  srdt_byte_type  shadow_cd;
  srdt_byte_type  dram_type;
  srdt_byte_type  next_index;
  logic           next_index_valid;
  srdt_byte_type  next_shadow_ab;
  srdt_byte_type  next_shadow_cd;
  srdt_byte_type  next_dram_type;
  srdt_byte_type  next_rdata;
  logic           next_rvalid;
  srdt_state_type state;
  srdt_state_type next_state;
  logic [2:0]     count;
  logic [2:0]     next_count;
  logic           cyc_prev;
  logic           next_prech;
  srdt_bank_type  dec_present;
  srdt_bank_type  dec_one_mb;
  logic           dec_valid;
  logic           wr_index;
  logic           wr_data;
  logic           rd_index;
  logic           rd_data;
  logic           fast_en;
  logic           long_prech;
  logic           cyc_rise;

  // --------------------------------------------------------------------------
  // Port decode
  // --------------------------------------------------------------------------

  // Tells whether the bus address hits the given port.
  function automatic logic port_hit(input srdt_addr_type a, input srdt_addr_type p);
    return a == p;
  endfunction : port_hit

  // Strobes qualified by port address.
  assign wr_index = IO_WR && port_hit(IO_ADDR, `SRDT_PORT_INDEX); // RULE_01
  assign wr_data  = IO_WR && port_hit(IO_ADDR, `SRDT_PORT_DATA);  // RULE_01
  assign rd_index = IO_RD && port_hit(IO_ADDR, `SRDT_PORT_INDEX);
  assign rd_data  = IO_RD && port_hit(IO_ADDR, `SRDT_PORT_DATA);

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------

  // Next values of index, registers and read data.
  always_comb begin
    next_index       = index;
    next_index_valid = index_valid;
    next_shadow_ab   = shadow_ab;
    next_shadow_cd   = shadow_cd;
    next_dram_type   = dram_type;
    next_rdata       = IO_RDATA;
    next_rvalid      = 1'b0;
    if (wr_index) begin
      next_index       = IO_WDATA; // RULE_01
      next_index_valid = 1'b1;
    end else if ((wr_data || rd_data) && index_valid) begin
      next_index_valid = 1'b0; // RULE_02
    end
    if (wr_data && index_valid) begin
      if (index == `SRDT_IDX_SHADOW_AB) begin
        next_shadow_ab = IO_WDATA; // RULE_04 RULE_05
      end else if (index == `SRDT_IDX_SHADOW_CD) begin
        next_shadow_cd = IO_WDATA; // RULE_06 RULE_07
      end else if (index == `SRDT_IDX_DRAM_TYPE) begin
        next_dram_type = IO_WDATA;
      end
    end
    if (rd_index) begin
      next_rvalid = 1'b1;
      next_rdata  = index;
    end else if (rd_data) begin
      next_rvalid = 1'b1;
      next_rdata  = `SRDT_READ_ZERO; // RULE_03 RULE_09
      if (!index_valid) begin
        next_rdata = `SRDT_READ_ZERO; // RULE_02
      end else if (index == `SRDT_IDX_SHADOW_AB) begin
        next_rdata = shadow_ab;
      end else if (index == `SRDT_IDX_SHADOW_CD) begin
        next_rdata = shadow_cd;
      end else if (index == `SRDT_IDX_DRAM_TYPE) begin
        next_rdata = dram_type;
      end
    end
  end

  // Registers the register file; all state has a defined reset value.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      index       <= `SRDT_RST_INDEX;
      index_valid <= 1'b0;
      shadow_ab   <= `SRDT_RST_SHADOW; // RULE_08
      shadow_cd   <= `SRDT_RST_SHADOW; // RULE_08
      dram_type   <= `SRDT_RST_DRAM_TYPE; // RULE_11 RULE_12
      IO_RDATA    <= `SRDT_READ_ZERO;
      IO_RVALID   <= 1'b0;
    end else begin
      index       <= next_index;
      index_valid <= next_index_valid;
      shadow_ab   <= next_shadow_ab;
      shadow_cd   <= next_shadow_cd;
      dram_type   <= next_dram_type;
      IO_RDATA    <= next_rdata;
      IO_RVALID   <= next_rvalid;
    end
  end

  // --------------------------------------------------------------------------
  // Shadow segment map
  // --------------------------------------------------------------------------

  // Segments ascend from A0000H; the A/B register holds the B area low.
  assign SHADOW_EN[3:0]   = shadow_ab[7:4]; // RULE_05
  assign SHADOW_EN[7:4]   = shadow_ab[3:0]; // RULE_04
  assign SHADOW_EN[15:8]  = shadow_cd;      // RULE_06 RULE_07

  // --------------------------------------------------------------------------
  // Row-strobe precharge sequencer
  // --------------------------------------------------------------------------
  assign fast_en    = dram_type[`SRDT_BIT_FAST_TIMEOUT];
  assign long_prech = dram_type[`SRDT_BIT_LONG_PRECH];
  assign cyc_rise   = (CYC_IO || CYC_IDLE) && !cyc_prev;

  // Starts a timed precharge when an I/O or idle cycle begins.
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      SRDT_ST_WAIT: begin
        if (fast_en && cyc_rise) begin
          next_state = SRDT_ST_PRECH; // RULE_10
          next_count = long_prech ? `SRDT_PRECH_LONG_M1 : `SRDT_PRECH_SHORT_M1; // RULE_12
        end
      end
      SRDT_ST_PRECH: begin
        if (!fast_en) begin
          next_state = SRDT_ST_WAIT; // RULE_11
        end else if (count == `SRDT_CNT_ZERO) begin
          next_state = (CYC_IO || CYC_IDLE) ? SRDT_ST_HOLD : SRDT_ST_WAIT;
        end else begin
          next_count = count - `SRDT_CNT_ONE;
        end
      end
      SRDT_ST_HOLD: begin
        if (!(CYC_IO || CYC_IDLE) || !fast_en) begin
          next_state = SRDT_ST_WAIT;
        end
      end
      default: begin
        next_state = SRDT_ST_WAIT;
      end
    endcase
    next_prech = (next_state == SRDT_ST_PRECH); // RULE_10 RULE_11
  end

  // Registers the sequencer and its output.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state         <= SRDT_ST_WAIT;
      count         <= `SRDT_CNT_ZERO;
      cyc_prev      <= 1'b0;
      RAS_PRECHARGE <= 1'b0;
    end else begin
      state         <= next_state;
      count         <= next_count;
      cyc_prev      <= CYC_IO || CYC_IDLE;
      RAS_PRECHARGE <= next_prech;
    end
  end

  // --------------------------------------------------------------------------
  // Bank population decode
  // --------------------------------------------------------------------------

  // Table lookup of the bank code.
  srdt_decode u_decode (
    .code    (dram_type[`SRDT_CODE_MSB:`SRDT_CODE_LSB]),
    .present (dec_present),
    .one_mb  (dec_one_mb),
    .valid   (dec_valid)
  );

  // Registers the decoded bank information.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      BANK_PRESENT <= `SRDT_BANKS_NONE;
      BANK_1MB     <= `SRDT_BANKS_NONE;
      TYPE_VALID   <= 1'b0;
    end else begin
      BANK_PRESENT <= dec_present; // RULE_13
      BANK_1MB     <= dec_one_mb;
      TYPE_VALID   <= dec_valid;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_index_write;
    @(posedge CLK) disable iff (!NRST)
      wr_index |=> index == $past(IO_WDATA) && index_valid;
  endproperty
  a_index_write: assert property (p_index_write) // RULE_01
    else $error("Index write not captured.");

  property p_index_consumed;
    @(posedge CLK) disable iff (!NRST)
      (wr_data || rd_data) && index_valid && !wr_index |=> !index_valid;
  endproperty
  a_index_consumed: assert property (p_index_consumed) // RULE_02
    else $error("Data access did not consume the index.");

  property p_no_index_no_write;
    @(posedge CLK) disable iff (!NRST)
      wr_data && !index_valid |=> $stable(shadow_ab) && $stable(shadow_cd) && $stable(dram_type);
  endproperty
  a_no_index_no_write: assert property (p_no_index_no_write) // RULE_02
    else $error("Data write without index changed a register.");

  property p_reserved_zero;
    @(posedge CLK) disable iff (!NRST)
      rd_data && index_valid && index == `SRDT_IDX_RESERVED
      |=> IO_RVALID && IO_RDATA == `SRDT_READ_ZERO;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RULE_09
    else $error("Reserved register did not read zero.");

  property p_ab_map;
    @(posedge CLK) disable iff (!NRST)
      wr_data && index_valid && index == `SRDT_IDX_SHADOW_AB
      |=> SHADOW_EN[7:0] == {$past(IO_WDATA[3:0]), $past(IO_WDATA[7:4])};
  endproperty
  a_ab_map: assert property (p_ab_map) // RULE_04
    else $error("A/B area segment map wrong.");

  property p_cd_map;
    @(posedge CLK) disable iff (!NRST)
      wr_data && index_valid && index == `SRDT_IDX_SHADOW_CD |=> SHADOW_EN[15:8] == $past(IO_WDATA);
  endproperty
  a_cd_map: assert property (p_cd_map) // RULE_06
    else $error("C/D area segment map wrong.");

  property p_prech_start;
    @(posedge CLK) disable iff (!NRST)
      state == SRDT_ST_WAIT && fast_en && cyc_rise |=> RAS_PRECHARGE;
  endproperty
  a_prech_start: assert property (p_prech_start) // RULE_10
    else $error("Precharge did not start.");

  property p_prech_off;
    @(posedge CLK) disable iff (!NRST)
      !fast_en |=> !RAS_PRECHARGE;
  endproperty
  a_prech_off: assert property (p_prech_off) // RULE_11
    else $error("Precharge while disabled.");

  property p_prech_long;
    @(posedge CLK) disable iff (!NRST)
      $rose(RAS_PRECHARGE) && $past(long_prech) ##0 fast_en[*5]
      |-> RAS_PRECHARGE && $past(RAS_PRECHARGE) && $past(RAS_PRECHARGE, 2)
          && $past(RAS_PRECHARGE, 3) ##1 !RAS_PRECHARGE;
  endproperty
  a_prech_long: assert property (p_prech_long) // RULE_12
    else $error("Long precharge not five cycles.");

  property p_prech_short;
    @(posedge CLK) disable iff (!NRST)
      $rose(RAS_PRECHARGE) && !$past(long_prech) ##0 fast_en[*3]
      |-> RAS_PRECHARGE && $past(RAS_PRECHARGE) ##1 !RAS_PRECHARGE;
  endproperty
  a_prech_short: assert property (p_prech_short) // RULE_12
    else $error("Short precharge not three cycles.");

  property p_bank_follow;
    @(posedge CLK) disable iff (!NRST)
      1'b1 |=> BANK_PRESENT == $past(dec_present) && TYPE_VALID == $past(dec_valid)
               && BANK_1MB == $past(dec_one_mb)
               && (BANK_1MB & ~BANK_PRESENT) == `SRDT_BANKS_NONE;
  endproperty
  a_bank_follow: assert property (p_bank_follow) // RULE_13
    else $error("Bank outputs do not follow code.");

endmodule : srdt_regs

//--- design/srdt_consts.svh
`ifndef SRDT_CONSTS_SVH
`define SRDT_CONSTS_SVH

// ----------------------------------------------------------------------------
// I/O ports and register indices
// ----------------------------------------------------------------------------
`define SRDT_PORT_INDEX        16'h0022
`define SRDT_PORT_DATA         16'h0023
`define SRDT_IDX_SHADOW_AB     8'hb6
`define SRDT_IDX_SHADOW_CD     8'hb7
`define SRDT_IDX_RESERVED      8'hb8
`define SRDT_IDX_DRAM_TYPE     8'hb9

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SRDT_RST_SHADOW        8'h00
`define SRDT_RST_DRAM_TYPE     8'h02
`define SRDT_RST_INDEX         8'h00
`define SRDT_READ_ZERO         8'h00

// ----------------------------------------------------------------------------
// Field positions of the memory-type register
// ----------------------------------------------------------------------------
`define SRDT_BIT_FAST_TIMEOUT  0
`define SRDT_BIT_LONG_PRECH    1
`define SRDT_CODE_MSB          7
`define SRDT_CODE_LSB          2

// ----------------------------------------------------------------------------
// Precharge lengths in double-rate clock cycles, loaded as length minus one
// ----------------------------------------------------------------------------
`define SRDT_PRECH_LONG_M1     3'h4
`define SRDT_PRECH_SHORT_M1    3'h2
`define SRDT_CNT_ZERO          3'h0
`define SRDT_CNT_ONE           3'h1

// ----------------------------------------------------------------------------
// Bank population codes, bits 7 to 2
// ----------------------------------------------------------------------------
`define SRDT_CODE_A            6'h20
`define SRDT_CODE_B            6'h28
`define SRDT_CODE_C            6'h2c
`define SRDT_CODE_D            6'h2d
`define SRDT_CODE_E            6'h2e
`define SRDT_CODE_F            6'h2f
`define SRDT_CODE_G            6'h18
`define SRDT_CODE_H            6'h30
`define SRDT_CODE_I            6'h38
`define SRDT_CODE_J            6'h3e
`define SRDT_CODE_K            6'h3f
`define SRDT_BANKS_NONE        4'h0
`define SRDT_BANKS_1           4'h1
`define SRDT_BANKS_2           4'h3
`define SRDT_BANKS_3           4'h7
`define SRDT_BANKS_4           4'hf
`define SRDT_MB_B0             4'h1
`define SRDT_MB_B1             4'h2
`define SRDT_MB_B01            4'h3
`define SRDT_MB_B2             4'h4
`define SRDT_MB_B012           4'h7
`define SRDT_MB_B23            4'hc

`endif

//--- design/srdt_pkg.sv
package srdt_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef logic [7:0]  srdt_byte_type;
  typedef logic [15:0] srdt_addr_type;
  typedef logic [15:0] srdt_seg_type;
  typedef logic [3:0]  srdt_bank_type;

  // Precharge sequencer states, one-hot.
  typedef enum logic [2:0] {
    SRDT_ST_WAIT  = 3'b001,
    SRDT_ST_PRECH = 3'b010,
    SRDT_ST_HOLD  = 3'b100
  } srdt_state_type;

endpackage : srdt_pkg

//--- design/srdt_decode.sv
`include "srdt_consts.svh"

module srdt_decode
  import srdt_pkg::*;
(
  input  wire logic [5:0]    code,      // Bank code, bits 7 to 2.
  output srdt_bank_type      present,   // Populated banks.
  output srdt_bank_type      one_mb,    // Banks using 1Mb parts.
  output logic               valid      // Code is a listed one.
);

  // --------------------------------------------------------------------------
  // Code table
  // --------------------------------------------------------------------------

  // Maps a bank code onto valid, 1Mb flags and populated banks.
  function automatic logic [8:0] decode_code(input logic [5:0] c);
    logic [8:0] r;
    r = {1'b0, `SRDT_BANKS_NONE, `SRDT_BANKS_NONE};
    case (c)
      `SRDT_CODE_A: r = {1'b1, `SRDT_BANKS_NONE, `SRDT_BANKS_1};
      `SRDT_CODE_B: r = {1'b1, `SRDT_BANKS_NONE, `SRDT_BANKS_2};
      `SRDT_CODE_C: r = {1'b1, `SRDT_BANKS_NONE, `SRDT_BANKS_3};
      `SRDT_CODE_D: r = {1'b1, `SRDT_BANKS_NONE, `SRDT_BANKS_4};
      `SRDT_CODE_E: r = {1'b1, `SRDT_MB_B2, `SRDT_BANKS_3};
      `SRDT_CODE_F: r = {1'b1, `SRDT_MB_B23, `SRDT_BANKS_4};
      `SRDT_CODE_G: r = {1'b1, `SRDT_MB_B1, `SRDT_BANKS_2};
      `SRDT_CODE_H: r = {1'b1, `SRDT_MB_B0, `SRDT_BANKS_1};
      `SRDT_CODE_I: r = {1'b1, `SRDT_MB_B01, `SRDT_BANKS_2};
      `SRDT_CODE_J: r = {1'b1, `SRDT_MB_B012, `SRDT_BANKS_3};
      `SRDT_CODE_K: r = {1'b1, `SRDT_BANKS_4, `SRDT_BANKS_4};
      default:      r = {1'b0, `SRDT_BANKS_NONE, `SRDT_BANKS_NONE};
    endcase
    return r;
  endfunction : decode_code

  // Unlisted codes decode to no banks and a cleared valid flag.
  assign {valid, one_mb, present} = decode_code(code); // RULE_13

endmodule : srdt_decode

//--- tb/test_shadow_ram_and_dram_type_config.sv
module test_shadow_ram_and_dram_type_config
  import srdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------------------
  logic          clk;
  logic          nrst;
  logic          io_wr;
  logic          io_rd;
  logic          cyc_io;
  logic          cyc_idle;
  srdt_addr_type io_addr;
  srdt_byte_type io_wdata;
  srdt_byte_type io_rdata;
  logic          io_rvalid;
  logic          ras_precharge;
  logic          type_valid;
  srdt_seg_type  shadow_en;
  srdt_bank_type bank_present;
  srdt_bank_type bank_1mb;
  int            fails;
  int            checks;
  int            seed;
  int            m_ab;
  int            m_cd;
  int            m_ty;
  int            m_idx;
  int            m_iv;
  int            i;
  int            k;

  // Listed bank codes with their populated banks and their 1Mb banks.
  localparam logic [13:0] bank_tab [11] = '{
    {6'h20, 4'h1, 4'h0}, {6'h28, 4'h3, 4'h0}, {6'h2c, 4'h7, 4'h0}, {6'h2d, 4'hf, 4'h0},
    {6'h2e, 4'h7, 4'h4}, {6'h2f, 4'hf, 4'hc}, {6'h18, 4'h3, 4'h2}, {6'h30, 4'h1, 4'h1},
    {6'h38, 4'h3, 4'h3}, {6'h3e, 4'h7, 4'h7}, {6'h3f, 4'hf, 4'hf}};

  // Device under test.
  srdt_regs i_dut (
    .CLK(clk), .NRST(nrst), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
    .IO_WDATA(io_wdata), .CYC_IO(cyc_io), .CYC_IDLE(cyc_idle), .IO_RDATA(io_rdata),
    .IO_RVALID(io_rvalid), .SHADOW_EN(shadow_en), .RAS_PRECHARGE(ras_precharge),
    .BANK_PRESENT(bank_present), .BANK_1MB(bank_1mb), .TYPE_VALID(type_valid));

  // The clock toggles every half period of 10 ns.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------------------
  // Comparison, model and bus tasks
  // ----------------------------------------------------------------------------
  // Compares one design value with its expected value and counts the result.
  task automatic chk(input string what, input int exp, input logic [15:0] got);
    checks++;
    if (got !== exp[15:0]) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp[15:0], got);
    end
  endtask : chk

  // Returns the modelled contents of an indexed register, zero when unmapped.
  function automatic int model_reg(input int idx);
    case (idx)
      'hb6: return m_ab;
      'hb7: return m_cd;
      'hb9: return m_ty;
      default: return 0;
    endcase
  endfunction : model_reg

  // Writes one byte to an I/O address and updates the model.
  task automatic io_write(input int addr, input int data);
    @(posedge clk);
    io_addr  <= addr[15:0];
    io_wdata <= data[7:0];
    io_wr    <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    if (addr == 'h22) begin
      m_idx = data & 'hff;
      m_iv  = 1;
    end else if (addr == 'h23) begin
      if (m_iv != 0 && m_idx == 'hb6) m_ab = data & 'hff;
      if (m_iv != 0 && m_idx == 'hb7) m_cd = data & 'hff;
      if (m_iv != 0 && m_idx == 'hb9) m_ty = data & 'hff;
      m_iv = 0;
    end
  endtask : io_write

  // Reads one I/O address and compares the answer with the model.
  task automatic io_read(input int addr);
    int exp;
    @(posedge clk);
    io_addr <= addr[15:0];
    io_rd   <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    exp = (addr == 'h22) ? m_idx : ((m_iv != 0) ? model_reg(m_idx) : 0);
    #1;
    chk("read valid", (addr == 'h22 || addr == 'h23), io_rvalid);
    if (addr == 'h22 || addr == 'h23) chk("read data", exp, io_rdata);
    if (addr == 'h23) m_iv = 0;
    @(posedge clk);
    #1;
    chk("read valid drop", 0, io_rvalid);
  endtask : io_read

  // Selects an index, writes it and reads it back through a fresh index.
  task automatic reg_write_back(input int idx, input int data);
    io_write('h22, idx);
    io_write('h23, data);
    io_write('h22, idx);
    io_read('h23);
  endtask : reg_write_back

  // Compares the decoded outputs with the model once they have settled.
  task automatic check_outs();
    int se;
    int pres;
    int mb;
    int ok;
    @(posedge clk);
    #1;
    se   = ((m_ab >> 4) & 'hf) | ((m_ab & 'hf) << 4) | ((m_cd & 'hff) << 8);
    pres = 0;
    mb   = 0;
    ok   = 0;
    for (int n = 0; n < 11; n++) begin
      if (bank_tab[n][13:8] == m_ty[7:2]) begin
        pres = bank_tab[n][7:4];
        mb   = bank_tab[n][3:0];
        ok   = 1;
      end
    end
    chk("shadow enables", se, shadow_en);
    chk("banks present", pres, bank_present);
    chk("banks 1mb", mb, bank_1mb);
    chk("type valid", ok, type_valid);
  endtask : check_outs

  // Raises an I/O or idle cycle level and counts the precharge cycles.
  task automatic prech(input int use_io);
    int n;
    int exp;
    exp = ((m_ty & 1) != 0) ? (((m_ty & 2) != 0) ? 5 : 3) : 0;
    n   = 0;
    @(posedge clk);
    cyc_io   <= (use_io != 0);
    cyc_idle <= (use_io == 0);
    repeat (12) begin
      @(posedge clk);
      #1;
      if (ras_precharge === 1'b1) n++;
    end
    chk("precharge cycles", exp, n[15:0]);
    @(posedge clk);
    cyc_io   <= 1'b0;
    cyc_idle <= 1'b0;
    @(posedge clk);
  endtask : prech

  // Holds reset for eight cycles and restores the model defaults.
  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst  <= 1'b1;
    m_ab  = 0;
    m_cd  = 0;
    m_ty  = 'h02;
    m_idx = 0;
    m_iv  = 0;
  endtask : do_reset

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------------
  // Runs every scenario in turn from a clean reset.
  initial begin
    seed     = 32'h936a;
    fails    = 0;
    checks   = 0;
    nrst     = 1'b0;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_addr  = 16'h0000;
    io_wdata = 8'h00;
    cyc_io   = 1'b0;
    cyc_idle = 1'b0;
    do_reset();
    check_outs();
    for (i = 'hb6; i <= 'hb9; i++) begin
      io_write('h22, i);
      io_read('h23);
    end
    $display("test reset values done");
    for (i = 0; i < 16; i++) begin
      reg_write_back((i < 8) ? 'hb6 : 'hb7, 1 << (i % 8));
      check_outs();
    end
    repeat (20) begin
      k = $random(seed);
      if (((k >> 8) & 3) == 3) k = k & 'hffffff00;
      reg_write_back('hb5 + ((k >> 8) & 3), k & 'hff);
      check_outs();
    end
    $display("test shadow enables done");
    io_write('h22, 'hb6);
    io_write('h23, 'h5a);
    io_write('h23, 'ha5);
    io_read('h23);
    io_read('h22);
    io_write('h22, 'hb7);
    io_write('h0123, 'h77);
    io_write('h24, 'h66);
    io_read('h0122);
    io_read('h23);
    check_outs();
    $display("test index handling done");
    for (i = 0; i < 13; i++) begin
      k = (i < 11) ? bank_tab[i][13:8] : ((i == 11) ? 'h00 : 'h21);
      reg_write_back('hb9, k << 2);
      check_outs();
    end
    $display("test bank codes done");
    for (i = 0; i < 8; i++) begin
      reg_write_back('hb9, 'h80 | (i & 3));
      prech(i / 4);
    end
    // Clears the enable bit while a long precharge runs; it must stop at once.
    io_write('h22, 'hb9);
    @(posedge clk);
    cyc_idle <= 1'b1;
    io_write('h23, 'h80);
    #1;
    chk("precharge before cut", 1, ras_precharge);
    @(posedge clk);
    #1;
    chk("precharge after cut", 0, ras_precharge);
    @(posedge clk);
    cyc_idle <= 1'b0;
    @(posedge clk);
    $display("test precharge done");
    reg_write_back('hb6, 'hff);
    do_reset();
    check_outs();
    io_write('h22, 'hb9);
    io_read('h23);
    prech(1);
    $display("test second reset done");
    report_and_stop();
  end

  // Cuts a hang short well after the sequence should have ended.
  initial begin
    #200us;
    fails++;
    $display("FAIL watchdog expected end seen timeout");
    report_and_stop();
  end

endmodule : test_shadow_ram_and_dram_type_config
